/* core/adc_bus_host.sv */
`timescale 1ns/1ps
module adc_bus_host
  import adc_host_pkg::*;
#(
  parameter int CHAN_W = 3
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          req,
  input  wire logic                          req_mode,
  input  wire logic [CHAN_W-1:0]             req_chan,
  output logic                               busy,
  output logic                               result_valid,
  output logic [adc_host_pkg::RESULT_W-1:0]  result,
  output logic                               timeout,
  output logic                               select_n,
  output logic                               read_n,
  output logic [CHAN_W-1:0]                  chan_sel,
  input  wire logic [adc_host_pkg::RESULT_W-1:0] result_bus,
  input  wire logic                          eoc_n,
  input  wire logic                          wait_req
);
  import adc_host_pkg::*;

  // only the four- and eight-channel address widths exist on the converter
  if (CHAN_W != 2 && CHAN_W != 3) begin : g_chan_chk
    $error("CHAN_W must be 2 or 3");
  end

  // ****************************************************************
  // state and registers
  // ****************************************************************
  host_state_t           state_r, state_nxt;
  logic                  mode_r;
  logic [CHAN_W-1:0]     chan_r;
  logic [CNT_W-1:0]      wait_cnt_r;
  logic                  timeout_r;
  logic                  valid_r;
  logic                  busy_r;
  logic [RESULT_W-1:0]   result_r;
  logic                  select_n_r;
  logic                  read_n_r;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic             start      = (state_r == ST_IDLE) && req;
  wire logic             gap_done;
  wire logic             strobe_end = (state_r == ST_STROBE) && gap_done;
  // the device releases ready when the result appears on the bus
  wire logic             wait_over  = (state_r == ST_WAIT) && wait_req;
  wire logic             wait_stuck = (state_r == ST_WAIT) && (wait_cnt_r == CNT_W'(WAIT_LIMIT));
  wire logic             gap_load   = start || (state_r == ST_CAPTURE);
  // no-wait reads are spaced by the full cycle, wait reads by recovery only
  wire logic [CNT_W-1:0] gap_count  = start ? CNT_W'(STROBE_CYCLES)
                                    : (mode_r == MODE_NOWAIT) ? CNT_W'(SPACING_CYCLES)
                                    : CNT_W'(RECOVERY_CYCLES);
  wire logic             bus_latch  = (state_r == ST_CAPTURE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:    if (req) state_nxt = ST_STROBE;
      ST_STROBE:  if (gap_done) state_nxt = (mode_r == MODE_WAIT) ? ST_WAIT : ST_CAPTURE;
      ST_WAIT:    if (wait_over || wait_stuck) state_nxt = ST_CAPTURE;
      ST_CAPTURE: state_nxt = ST_GAP;
      ST_GAP:     if (gap_done) state_nxt = ST_IDLE;
      default:    state_nxt = ST_IDLE;
    endcase
  end

  gap_timer #(.W(CNT_W)) u_gap (
    .mclk  (mclk),
    .rst   (rst),
    .load  (gap_load),
    .count (gap_count),
    .done  (gap_done)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // busy is registered from the next state so it tracks state_r exactly
  // while still coming straight from a flip-flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != ST_IDLE);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_WAIT;
      chan_r <= '0;
    end else if (start) begin
      mode_r <= req_mode;
      chan_r <= req_chan;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_cnt_r <= '0;
    end else if (state_r != ST_WAIT) begin
      wait_cnt_r <= '0;
    end else if (!wait_stuck) begin
      wait_cnt_r <= wait_cnt_r + CNT_W'(1);
    end
  end

  // ****************************************************************
  // pins: select held low through the read, read strobe alongside
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      select_n_r <= 1'b1;
      read_n_r   <= 1'b1;
    end else begin
      select_n_r <= !(state_nxt == ST_STROBE || state_nxt == ST_WAIT
                      || state_nxt == ST_CAPTURE);
      read_n_r   <= !(state_nxt == ST_STROBE || state_nxt == ST_WAIT
                      || state_nxt == ST_CAPTURE);
    end
  end

  // ****************************************************************
  // result capture: the bus is sampled while still selected
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_r  <= RESULT_RST;
      valid_r   <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      valid_r <= bus_latch;
      if (bus_latch) begin
        // no-wait mode returns the previous conversion's code
        result_r  <= result_bus;
        timeout_r <= (mode_r == MODE_WAIT) && !wait_req;
      end
    end
  end

  assign busy         = busy_r;
  assign result_valid = valid_r;
  assign result       = result_r;
  assign timeout      = timeout_r;
  assign select_n     = select_n_r;
  assign read_n       = read_n_r;
  assign chan_sel     = chan_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  strobe_len_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_r == ST_STROBE) |-> !read_n [*2])
    else $error("read strobe shorter than minimum");
  wait_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && !wait_req) |=> !read_n && !select_n)
    else $error("read released while wait requested");
  chan_stable_a: assert property (@(posedge mclk) disable iff (rst)
    (!select_n && $past(!select_n)) |-> $stable(chan_sel))
    else $error("channel changed during read");
  spacing_a: assert property (@(posedge mclk) disable iff (rst)
    ($rose(select_n) && mode_r == MODE_NOWAIT) |-> select_n [*8])
    else $error("no-wait reads too close");
  recovery_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(select_n) |-> select_n [*8])
    else $error("recovery gap too short");
  pair_a: assert property (@(posedge mclk) disable iff (rst)
    select_n == read_n)
    else $error("select and read not paired");
  valid_a: assert property (@(posedge mclk) disable iff (rst)
    result_valid |-> $past(!select_n))
    else $error("result taken outside a read");
  wait_bound_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(state_r == ST_WAIT) |-> ##[1:210] (state_r != ST_WAIT))
    else $error("wait not bounded");
  busy_track_a: assert property (@(posedge mclk) disable iff (rst)
    !select_n |-> busy)
    else $error("select low while sequencer idle");

  cov_wait_c: cover property (@(posedge mclk) disable iff (rst)
    result_valid && mode_r == MODE_WAIT && !timeout);
  cov_nowait_c: cover property (@(posedge mclk) disable iff (rst)
    result_valid && mode_r == MODE_NOWAIT);
  cov_timeout_c: cover property (@(posedge mclk) disable iff (rst) timeout);
  cov_gap_end_c: cover property (@(posedge mclk) disable iff (rst)
    $fell(busy) && mode_r == MODE_NOWAIT);
endmodule

/* core/adc_host_pkg.sv */
package adc_host_pkg;

  // ****************************************************************
  // timing of the converter as seen from the host
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CONV_TIME_NS    = 2000;
  localparam int RECOVERY_NS     = 500;
  localparam int READ_SPACING_NS = 2500;
  localparam int STROBE_NS       = 100;
  localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPACING_CYCLES  = (READ_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_LIMIT      = 200;
  localparam int CNT_W           = 8;

  // ****************************************************************
  // widths and modes
  // ****************************************************************
  localparam int RESULT_W = 8;
  localparam logic MODE_WAIT   = 1'b0;
  localparam logic MODE_NOWAIT = 1'b1;
  localparam logic [7:0] RESULT_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STROBE,
    ST_WAIT,
    ST_CAPTURE,
    ST_GAP
  } host_state_t;

endpackage

/* core/gap_timer.sv */
`timescale 1ns/1ps
module gap_timer
  import adc_host_pkg::*;
#(
  parameter int W = adc_host_pkg::CNT_W
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;

  // refused at elaboration: a one-bit counter cannot hold any useful gap
  if (W < 2) begin : g_width_chk
    $error("gap_timer width too small");
  end

  assign done = (cnt_r == '0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (!done) begin
      cnt_r <= cnt_r - W'(1);
    end
  end
endmodule

/* tb/adc_dev_model.sv */
`timescale 1ns/1ps
module adc_dev_model (
  input  wire logic       select_n,
  input  wire logic       read_n,
  input  wire logic [2:0] chan_sel,
  input  wire logic       hang,
  output logic [7:0]      result_bus,
  output logic            eoc_n,
  output logic            wait_req
);
  // ********************************
  // self-timed conversion
  // ********************************
  logic [7:0] out_r = 8'h00;
  logic [7:0] code;
  logic [7:0] last_r = 8'h00;
  logic       done = 1'b1;
  logic       track = 1'b0;
  wire        rd = !select_n && !read_n;
  initial eoc_n = 1'b1;
  always @(negedge select_n or negedge read_n) begin
    if (rd) begin
      code = (chan_sel == 3'h0) ? 8'h00 : (chan_sel == 3'h7) ? 8'hFF : {1'b0, chan_sel, 4'hA};
      done = 1'b0;
      track = 1'b1;
      fork
        begin
          #1000 track = 1'b0;
          out_r[7:4] = code[7:4];
          #600 out_r[3:0] = code[3:0];
          done = 1'b1;
          eoc_n = 1'b0;
        end
      join_none
    end
  end
  always @(posedge select_n or posedge read_n) eoc_n = 1'b1;
  // hang is a fault the bench commands: ready never released while selected
  assign wait_req = select_n || (done && !hang);
  // ********************************
  // data bus
  // ********************************
  // limitation: old data is shown during tracking in both modes, since the
  // strobe length is not known yet; a floating bus shows the inverse of last
  always @* begin
    if (rd && (track || done))
      last_r = out_r;
    result_bus = (rd && (track || done)) ? out_r : ~last_r;
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import adc_host_pkg::*;
  logic       mclk, rst, req, req_mode, hang, busy, result_valid, timeout;
  logic       select_n, read_n, eoc_n, wait_req, got_to;
  logic [2:0] req_chan, chan_sel;
  logic [7:0] result, result_bus, got;
  int         fails = 0;
  int         total_checks = 0;
  int         gap;
  adc_bus_host #(.CHAN_W(3)) dut (.mclk(mclk), .rst(rst), .req(req), .req_mode(req_mode),
    .req_chan(req_chan), .busy(busy), .result_valid(result_valid), .result(result),
    .timeout(timeout), .select_n(select_n), .read_n(read_n), .chan_sel(chan_sel),
    .result_bus(result_bus), .eoc_n(eoc_n), .wait_req(wait_req));
  adc_dev_model dev (.select_n(select_n), .read_n(read_n), .chan_sel(chan_sel), .hang(hang),
    .result_bus(result_bus), .eoc_n(eoc_n), .wait_req(wait_req));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ********************************
  // helpers
  // ********************************
  function automatic logic [7:0] level(input logic [2:0] c);
    return (c == 3'h0) ? 8'h00 : (c == 3'h7) ? 8'hFF : {1'b0, c, 4'hA};
  endfunction
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  task do_read(input logic m, input logic [2:0] c);
    int n;
    @(posedge mclk);
    req <= 1'b1;
    req_mode <= m;
    req_chan <= c;
    @(posedge mclk);
    req <= 1'b0;
    @(negedge mclk);
    chk("select", 8'h00, {7'h0, select_n});
    chk("read", 8'h00, {7'h0, read_n});
    chk("chan", {5'h0, c}, {5'h0, chan_sel});
    n = 0;
    while (result_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    got = result;
    got_to = timeout;
    chk("valid", 8'h01, {7'h0, result_valid});
    gap = 0;
    while (busy !== 1'b0 && gap < 100) begin
      @(negedge mclk);
      gap++;
    end
    chk("idle", 8'h00, {7'h0, busy});
  endtask
  task final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task test_reset;
    chk("select idle", 8'h01, {7'h0, select_n});
    chk("result", RESULT_RST, result);
    $display("test reset done");
  endtask
  task test_wait;
    for (int c = 0; c < 8; c++) begin
      do_read(MODE_WAIT, 3'(c));
      chk("wait result", level(3'(c)), got);
      chk("no timeout", 8'h00, {7'h0, got_to});
      chk("recovery", 8'h01, {7'h0, gap >= 9});
    end
    $display("test wait done");
  endtask
  task test_nowait;
    do_read(MODE_NOWAIT, 3'h2);
    chk("stale", level(3'h7), got);
    chk("spacing", 8'h01, {7'h0, gap >= 45});
    do_read(MODE_NOWAIT, 3'h5);
    chk("previous", level(3'h2), got);
    $display("test nowait done");
  endtask
  task test_hang;
    hang <= 1'b1;
    do_read(MODE_WAIT, 3'h1);
    chk("timeout", 8'h01, {7'h0, got_to});
    hang <= 1'b0;
    do_read(MODE_WAIT, 3'h3);
    chk("recover", level(3'h3), got);
    $display("test hang done");
  endtask
  initial begin
    #(5000 * 50);
    fails++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    req_mode = 1'b0;
    req_chan = 3'h0;
    hang = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    test_reset;
    test_wait;
    test_nowait;
    test_hang;
    final_report;
  end
endmodule
